// [hsi_pkg.sv]
package hsi_pkg;

    // ************************************************************
    // bus rates and address layout
    // ************************************************************
    localparam int       SCL_STD_KHZ  = 100;   // standard mode
    localparam int       SCL_FAST_KHZ = 400;   // fast mode
    localparam int       SCL_HS_KHZ   = 3400;  // high-speed mode
    localparam logic [5:0] ADDR_HEADER = 6'h14; // fixed 010100
    localparam logic [3:0] BYTE_DONE   = 4'h8;  // bits in one byte
    localparam logic [3:0] ACK_SEEN    = 4'h1;  // ack clock high seen
    localparam logic [3:0] CNT_ZERO    = 4'h0;
    localparam logic [7:0] BYTE_ZERO   = 8'h00;
    localparam logic       LINE_IDLE   = 1'b1;  // released bus level
    localparam int         BUF_DEPTH   = 2;

    // ************************************************************
    // slave sequencer states, gray along the usual path
    // ************************************************************
    typedef enum logic [2:0] {
        HSI_IDLE     = 3'b000,
        HSI_ADDR     = 3'b001,
        HSI_ADDR_ACK = 3'b011,
        HSI_RX       = 3'b010,
        HSI_RX_ACK   = 3'b110,
        HSI_TX       = 3'b111,
        HSI_TX_ACK   = 3'b101,
        HSI_IGNORE   = 3'b100
    } hsi_state_e;

endpackage : hsi_pkg

// [hsi_buf2.sv]
`timescale 1ns/100ps

// two-entry buffer so a stalled receiver loses no word
module hsi_buf2 #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             rst_n,
    // filling side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    import hsi_pkg::*;

    logic [WIDTH-1:0] mem_reg [BUF_DEPTH];
    logic [WIDTH-1:0] mem_next [BUF_DEPTH];
    logic             wr_ptr_reg, wr_ptr_next;
    logic             rd_ptr_reg, rd_ptr_next;
    logic [1:0]       count_reg, count_next;
    logic             push, pop;

    // honest full and empty from the fill count
    assign in_ready  = (count_reg != 2'h2);
    assign out_valid = (count_reg != 2'h0);
    assign out_data  = mem_reg[rd_ptr_reg];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // next pointers, count and storage
    always_comb begin
        mem_next    = mem_reg;
        wr_ptr_next = wr_ptr_reg;
        rd_ptr_next = rd_ptr_reg;
        count_next  = count_reg;
        if (push) begin
            mem_next[wr_ptr_reg] = in_data;
            wr_ptr_next = ~wr_ptr_reg;
        end
        if (pop) begin
            rd_ptr_next = ~rd_ptr_reg;
        end
        if (push && !pop) begin
            count_next = count_reg + 2'h1;
        end else if (pop && !push) begin
            count_next = count_reg - 2'h1;
        end
    end

    // register only
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mem_reg[0] <= '0;
            mem_reg[1] <= '0;
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg  <= 2'h0;
        end else begin
            mem_reg    <= mem_next;
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            count_reg  <= count_next;
        end
    end

endmodule : hsi_buf2

// [hsi_i2c_slave.sv]
`timescale 1ns/100ps

// Overview of operation
// - slave on the bus at 100 kHz, 400 kHz and 3.4 MHz clock rates
// - own shift register, bit timing from clock edges, address matching
// - in standby, wake only on a transfer carrying our own address
// - interrupt output for flow control with selectable active level
// - hold clock low to pause; master waits for clock high
// - no general call, no 10-bit addressing, no Fast-mode Plus
// - 7-bit addresses only, read/write flag in the lowest bit
// - address is 010100, select pin, read/write: 0x50..0x53
// - pins act as address select, data and clock when selected
// - a bus wake event moves the device from standby to active
module hsi_i2c_slave (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       rst_n,
    // configuration and power state
    input  wire logic       host_if_select,
    input  wire logic       irq_active_high,
    input  wire logic       standby_state,
    output logic            host_wake,
    // bus pins, open drain
    input  wire logic       slave_addr_select_pin,
    input  wire logic       host_serial_clock_pin_i,
    output logic            host_serial_clock_pin_o,
    output logic            host_serial_clock_pin_oe,
    input  wire logic       host_serial_data_pin_i,
    output logic            host_serial_data_pin_o,
    output logic            host_serial_data_pin_oe,
    // bytes written by the host
    output logic            rx_valid,
    input  wire logic       rx_ready,
    output logic [7:0]      rx_data,
    // bytes read by the host
    input  wire logic       tx_valid,
    output logic            tx_ready,
    input  wire logic [7:0] tx_data,
    // interrupt line
    output logic            host_irq
);
    import hsi_pkg::*;

    // ************************************************************
    // pin synchronisers and edge detection
    // ************************************************************
    logic       scl_s1, scl_s2, scl_s3;
    logic       sda_s1, sda_s2, sda_s3;
    logic       adr_s1, adr_s2;
    logic       scl_rise, scl_fall, start_det, stop_det;

    // first stage feeds only the second
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            scl_s1 <= LINE_IDLE;
            scl_s2 <= LINE_IDLE;
            scl_s3 <= LINE_IDLE;
            sda_s1 <= LINE_IDLE;
            sda_s2 <= LINE_IDLE;
            sda_s3 <= LINE_IDLE;
            adr_s1 <= 1'b0;
            adr_s2 <= 1'b0;
        end else begin
            scl_s1 <= host_serial_clock_pin_i;
            scl_s2 <= scl_s1;
            scl_s3 <= scl_s2;
            sda_s1 <= host_serial_data_pin_i;
            sda_s2 <= sda_s1;
            sda_s3 <= sda_s2;
            adr_s1 <= slave_addr_select_pin;
            adr_s2 <= adr_s1;
        end
    end

    // bit timing comes from the bus clock alone; the 20 MHz sampler
    // limits high-speed mode to masters that honour the stretch
    assign scl_rise  = scl_s2 & ~scl_s3;
    assign scl_fall  = ~scl_s2 & scl_s3;
    assign start_det = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
    assign stop_det  = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;

    // ************************************************************
    // slave sequencer
    // ************************************************************
    hsi_state_e state_reg, state_next;
    logic [3:0] cnt_reg, cnt_next;
    logic [7:0] shift_reg, shift_next;
    logic [7:0] tx_sh_reg, tx_sh_next;
    logic       rw_reg, rw_next;
    logic       loaded_reg, loaded_next;
    logic       wake_reg, wake_next;
    logic       irq_reg, irq_next;
    logic       addr_match;
    logic       byte_in;
    logic       buf_in_ready;
    logic       stretch_now;
    logic       hold_reg, hold_next;

    // only 7-bit header plus select pin matches; general call and the
    // 10-bit prefix never carry the header, so they are never acked
    assign addr_match = host_if_select &
        (shift_reg[7:1] == {ADDR_HEADER, adr_s2});
    assign byte_in    = (cnt_reg == BYTE_DONE) & ~scl_s2;
    assign tx_ready   = (state_reg == HSI_TX) & ~loaded_reg & tx_valid;

    always_comb begin
        state_next  = state_reg;
        cnt_next    = cnt_reg;
        shift_next  = shift_reg;
        tx_sh_next  = tx_sh_reg;
        rw_next     = rw_reg;
        loaded_next = loaded_reg;
        wake_next   = 1'b0;
        hold_next   = stretch_now;                 // stretch tail, one cycle
        // level chosen by configuration, asserted while bytes wait
        irq_next    = tx_valid ? irq_active_high : ~irq_active_high;
        if (!host_if_select) begin
            state_next = HSI_IDLE;
        end else if (start_det) begin
            state_next = HSI_ADDR;
            cnt_next   = CNT_ZERO;
            shift_next = BYTE_ZERO;
        end else if (stop_det) begin
            state_next = HSI_IDLE;
        end else begin
            case (state_reg)
                HSI_ADDR: begin
                    if (scl_rise) begin
                        shift_next = {shift_reg[6:0], sda_s2};
                        cnt_next   = cnt_reg + 4'h1;
                    end else if (byte_in) begin
                        cnt_next = CNT_ZERO;
                        rw_next  = shift_reg[0];
                        if (addr_match) begin
                            state_next = HSI_ADDR_ACK;
                            wake_next  = standby_state;
                        end else begin
                            state_next = HSI_IGNORE;
                        end
                    end
                end
                HSI_ADDR_ACK: begin
                    if (scl_rise) begin
                        cnt_next = ACK_SEEN;
                    end else if (scl_fall && cnt_reg == ACK_SEEN) begin
                        cnt_next    = CNT_ZERO;
                        loaded_next = 1'b0;
                        state_next  = rw_reg ? HSI_TX : HSI_RX;
                    end
                end
                HSI_RX: begin
                    if (scl_rise) begin
                        shift_next = {shift_reg[6:0], sda_s2};
                        cnt_next   = cnt_reg + 4'h1;
                    end else if (byte_in && buf_in_ready) begin
                        cnt_next   = CNT_ZERO;
                        state_next = HSI_RX_ACK;
                    end
                end
                HSI_RX_ACK: begin
                    if (scl_rise) begin
                        cnt_next = ACK_SEEN;
                    end else if (scl_fall && cnt_reg == ACK_SEEN) begin
                        cnt_next   = CNT_ZERO;
                        state_next = HSI_RX;
                    end
                end
                HSI_TX: begin
                    if (!loaded_reg) begin
                        if (tx_valid) begin
                            tx_sh_next  = tx_data;
                            loaded_next = 1'b1;
                        end
                    end else if (scl_fall) begin
                        tx_sh_next = {tx_sh_reg[6:0], 1'b1};
                        cnt_next   = cnt_reg + 4'h1;
                        if (cnt_reg == BYTE_DONE - 4'h1) begin
                            cnt_next   = CNT_ZERO;
                            state_next = HSI_TX_ACK;
                        end
                    end
                end
                HSI_TX_ACK: begin
                    if (scl_rise) begin
                        cnt_next = ACK_SEEN;
                        rw_next  = sda_s2;                     // master nack
                    end else if (scl_fall && cnt_reg == ACK_SEEN) begin
                        cnt_next    = CNT_ZERO;
                        loaded_next = 1'b0;
                        state_next  = rw_reg ? HSI_IGNORE : HSI_TX;
                        rw_next     = 1'b1;
                    end
                end
                HSI_IDLE, HSI_IGNORE: begin
                    cnt_next = CNT_ZERO;
                end
                default: begin
                    state_next = HSI_IDLE;
                end
            endcase
        end
    end

    // register only
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_reg  <= HSI_IDLE;
            cnt_reg    <= CNT_ZERO;
            shift_reg  <= BYTE_ZERO;
            tx_sh_reg  <= BYTE_ZERO;
            rw_reg     <= 1'b0;
            loaded_reg <= 1'b0;
            wake_reg   <= 1'b0;
            irq_reg    <= 1'b0;
            hold_reg   <= 1'b0;
        end else begin
            state_reg  <= state_next;
            cnt_reg    <= cnt_next;
            shift_reg  <= shift_next;
            tx_sh_reg  <= tx_sh_next;
            rw_reg     <= rw_next;
            loaded_reg <= loaded_next;
            wake_reg   <= wake_next;
            irq_reg    <= irq_next;
            hold_reg   <= hold_next;
        end
    end

    // ************************************************************
    // pin drive and outputs
    // ************************************************************
    // open drain: only ever pull low, the bench resolves the wire
    assign host_serial_clock_pin_o = 1'b0;
    assign host_serial_data_pin_o  = 1'b0;
    // stretch while scl is already low and a byte cannot move on;
    // the master must wait for the line to go high again
    // a finished write byte holds the clock until the buffer takes it; a read holds it until a byte is loaded
    assign stretch_now = host_if_select & (
        ((state_reg == HSI_RX) & byte_in) |
        ((state_reg == HSI_TX) & ~loaded_reg));
    // one extra low cycle so new data is set up before the clock rises
    assign host_serial_clock_pin_oe = host_if_select &
        (stretch_now | hold_reg);
    // ack low in address and write ack slots, data low for zero bits
    assign host_serial_data_pin_oe = host_if_select & (
        (state_reg == HSI_ADDR_ACK) | (state_reg == HSI_RX_ACK) |
        ((state_reg == HSI_TX) & loaded_reg & ~tx_sh_reg[7]));
    assign host_wake = wake_reg;
    assign host_irq  = irq_reg;

    // received bytes pass a two-entry buffer before the user side
    hsi_buf2 #(
        .WIDTH     (8)
    ) u_rx_buf (
        .clock     (clock),
        .rst_n     (rst_n),
        .in_valid  ((state_reg == HSI_RX) & byte_in),
        .in_ready  (buf_in_ready),
        .in_data   (shift_reg),
        .out_valid (rx_valid),
        .out_ready (rx_ready),
        .out_data  (rx_data)
    );

endmodule : hsi_i2c_slave

// [hsi_mst_model.sv]
`timescale 1ns/100ps
// ****
// bus master model
// ****
// open drain master: a high enable pulls its wire low
module hsi_mst_model (
    // bench clock, every change lands on its rising edge
    input  wire logic clock,
    // wire levels seen
    input  wire logic scl,
    input  wire logic sda,
    // pull enables
    output logic      scl_oe,
    output logic      sda_oe
);
    // both wires released at time zero
    initial begin
        scl_oe <= 1'b0;
        sda_oe <= 1'b0;
    end
    // quarter of a bus clock, 100 ns, so no change races the sampler
    task step;
        repeat (2) @(posedge clock);
    endtask : step
    // start or repeated start, clock left low
    task start;
        sda_oe <= 1'b0;
        step();
        scl_oe <= 1'b0;
        step();
        sda_oe <= 1'b1;
        step();
        scl_oe <= 1'b1;
    endtask : start
    // stop, both wires end released
    task stop;
        step();
        sda_oe <= 1'b1;
        step();
        scl_oe <= 1'b0;
        step();
        sda_oe <= 1'b0;
        step();
    endtask : stop
    // one clock: data set while low, sampled while high
    task bitx(input logic b, output logic r);
        step();
        sda_oe <= !b;
        step();
        scl_oe <= 1'b0;
        wait (scl); // slave may stretch, so wait for high
        step();
        r = sda;
        step();
        scl_oe <= 1'b1;
    endtask : bitx
    // byte msb first, then ack slot; mack pulls the ack low
    task xfer(input logic [7:0] w, input logic mack,
              output logic [7:0] r, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) bitx(w[i], r[i]);
        bitx(!mack, a);
        ack = !a;
    endtask : xfer
endmodule : hsi_mst_model

// [hsi_checker.sv]
`timescale 1ns/100ps
// ****
// port checker
// ****
module hsi_checker (
    // clock and reset
    input wire logic       clock,
    input wire logic       rst_n,
    // config and power
    input wire logic       host_if_select,
    input wire logic       irq_active_high,
    input wire logic       standby_state,
    input wire logic       host_wake,
    // bus
    input wire logic       host_serial_clock_pin_i,
    input wire logic       host_serial_clock_pin_o,
    input wire logic       host_serial_clock_pin_oe,
    input wire logic       host_serial_data_pin_o,
    input wire logic       host_serial_data_pin_oe,
    // streams and interrupt
    input wire logic       rx_valid,
    input wire logic       rx_ready,
    input wire logic [7:0] rx_data,
    input wire logic       tx_valid,
    input wire logic       tx_ready,
    input wire logic       host_irq
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // deselected block keeps off the wires
    AST_IDLE_OFF: assert property (
        !host_if_select [*2] |-> !host_serial_data_pin_oe
        && !host_serial_clock_pin_oe && !host_wake)
        else $error("pins used while deselected");
    // open drain, so a high is never driven
    AST_DRIVE_LOW: assert property (
        !host_serial_clock_pin_o && !host_serial_data_pin_o)
        else $error("bus pin driven high");
    // past guard skips the edge right after reset
    AST_IRQ_LEVEL: assert property (
        $past(rst_n) |-> host_irq ==
        ($past(tx_valid) ~^ $past(irq_active_high)))
        else $error("interrupt level wrong");
    AST_WAKE_ACK: assert property (
        host_wake |-> ##[0:12] host_serial_data_pin_oe)
        else $error("wake without acknowledge");
    AST_WAKE_SBY: assert property (
        host_wake |-> $past(standby_state))
        else $error("wake outside standby");
    AST_WAKE_PULSE: assert property (
        host_wake |=> !host_wake)
        else $error("wake longer than one cycle");
    // a taken byte ends the stretch after one cycle of data setup
    AST_TX_TAKE: assert property (
        tx_ready && tx_valid |=> !tx_ready
        ##1 !host_serial_clock_pin_oe)
        else $error("stretch kept after byte taken");
    AST_RX_HOLD: assert property (
        rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
        else $error("stalled byte lost");
    // data moves only while the clock wire is low
    AST_SDA_ON_LOW: assert property (
        $changed(host_serial_data_pin_oe) |-> !host_serial_clock_pin_i)
        else $error("data changed with clock high");
    CVR_WAKE: cover property (host_wake);
    CVR_STALL: cover property (rx_valid && !rx_ready ##1 rx_ready);
    CVR_TX: cover property (tx_ready && tx_valid);
endmodule : hsi_checker

bind hsi_i2c_slave hsi_checker u_chk (.*);

// [tb.sv]
`timescale 1ns/100ps
// ****
// testbench
// ****
module tb;
    logic       clock = 1'b0;
    logic       rst_n = 1'b0;
    logic       host_if_select = 1'b1;
    logic       irq_active_high = 1'b1;
    logic       standby_state = 1'b1;
    logic       slave_addr_select_pin = 1'b0;
    logic       rx_ready = 1'b1;
    logic       tx_valid = 1'b1;
    logic [7:0] tx_data = 8'hc3;
    wire logic  host_serial_clock_pin_i;
    wire logic  host_serial_data_pin_i;
    logic       host_wake, host_irq, rx_valid, tx_ready;
    logic       host_serial_clock_pin_o, host_serial_clock_pin_oe;
    logic       host_serial_data_pin_o, host_serial_data_pin_oe;
    logic [7:0] rx_data, rd;
    logic       m_scl_oe, m_sda_oe, ak;
    int         err_count = 0, n_checks = 0, wake_n = 0, w0;
    logic [7:0] rxq[$];
    // rows: select pin, expected ack, address byte
    logic [9:0] rows [9] = '{10'h150, 10'h151, 10'h052, 10'h352,
        10'h353, 10'h250, 10'h000, 10'h0f0, 10'h058};

    always #25 clock = ~clock;
    // pull-ups: a wire is low while any party pulls it
    assign host_serial_clock_pin_i = !(m_scl_oe | host_serial_clock_pin_oe);
    assign host_serial_data_pin_i = !(m_sda_oe | host_serial_data_pin_oe);

    hsi_i2c_slave DUT (.*);
    hsi_mst_model u_mst (
        .clock  (clock),
        .scl    (host_serial_clock_pin_i),
        .sda    (host_serial_data_pin_i),
        .scl_oe (m_scl_oe),
        .sda_oe (m_sda_oe)
    );

    // collect taken bytes and wake pulses
    always @(posedge clock) begin
        if (rx_valid === 1'b1 && rx_ready === 1'b1) rxq.push_back(rx_data);
        if (host_wake === 1'b1) wake_n++;
    end

    task tk(input int n);
        repeat (n) @(posedge clock);
    endtask : tk

    task chk(input string nm, input logic [7:0] seen,
             input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task wrap_up;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up

    initial begin
        tk(4);
        rst_n <= 1'b1;
        tk(4);
        // address table; pin settles well before each start
        foreach (rows[i]) begin
            tk(1);
            slave_addr_select_pin <= rows[i][9];
            tk(6);
            w0 = wake_n;
            u_mst.start();
            u_mst.xfer(rows[i][7:0], 1'b0, rd, ak);
            chk("ack", 8'(ak), 8'(rows[i][8]));
            chk("wake", 8'(wake_n - w0), 8'(rows[i][8]));
            if (ak === 1'b1 && rows[i][0]) begin
                u_mst.xfer(8'hff, 1'b0, rd, ak);
                chk("read", rd, 8'hc3);
            end else if (ak === 1'b1) begin
                u_mst.xfer(8'h96, 1'b0, rd, ak);
                tk(3);
                chk("rx", rxq.pop_front(), 8'h96);
            end
            u_mst.stop();
        end
        // stalled receiver: third byte held off by stretching
        tk(1);
        rx_ready <= 1'b0;
        slave_addr_select_pin <= 1'b0;
        tk(6);
        u_mst.start();
        u_mst.xfer(8'h50, 1'b0, rd, ak);
        for (int k = 1; k < 3; k++) u_mst.xfer(8'(8'h11 * k), 1'b0, rd, ak);
        fork
            u_mst.xfer(8'h33, 1'b0, rd, ak);
            begin
                tk(100);
                #1 chk("stretch", 8'(host_serial_clock_pin_oe), 8'h01);
                tk(1);
                rx_ready <= 1'b1;
            end
        join
        chk("stall ack", 8'(ak), 8'h01);
        u_mst.stop();
        tk(4);
        for (int k = 1; k < 4; k++) begin
            chk("stall rx", rxq.pop_front(), 8'(8'h11 * k));
        end
        // read with nothing pending; interrupt idles meanwhile
        tk(1);
        tx_valid <= 1'b0;
        tk(3);
        #1 chk("irq idle", 8'(host_irq), 8'h00);
        u_mst.start();
        u_mst.xfer(8'h51, 1'b0, rd, ak);
        fork
            u_mst.xfer(8'hff, 1'b0, rd, ak);
            begin
                tk(20);
                #1 chk("tx hold", 8'(host_serial_clock_pin_oe), 8'h01);
                tk(1);
                tx_data <= 8'h5a;
                tx_valid <= 1'b1;
            end
        join
        chk("tx byte", rd, 8'h5a);
        u_mst.stop();
        tk(2);
        #1 chk("irq high", 8'(host_irq), 8'h01);
        tk(1);
        irq_active_high <= 1'b0;
        tk(2);
        #1 chk("irq low", 8'(host_irq), 8'h00);
        // deselected block ignores its own address
        tk(1);
        host_if_select <= 1'b0;
        tk(2);
        u_mst.start();
        u_mst.xfer(8'h50, 1'b0, rd, ak);
        u_mst.stop();
        chk("desel ack", 8'(ak), 8'h00);
        // reset in mid-run drops a held byte
        tk(1);
        host_if_select <= 1'b1;
        rx_ready <= 1'b0;
        tk(3);
        u_mst.start();
        u_mst.xfer(8'h50, 1'b0, rd, ak);
        u_mst.xfer(8'h77, 1'b0, rd, ak);
        u_mst.stop();
        tk(1);
        chk("held", 8'(rx_valid), 8'h01);
        rst_n <= 1'b0;
        tk(1);
        #1 chk("rst rx", 8'(rx_valid), 8'h00);
        chk("rst irq", 8'(host_irq), 8'h00);
        tk(1);
        rst_n <= 1'b1;
        rx_ready <= 1'b1;
        tk(4);
        chk("rst drop", 8'(rxq.size()), 8'h00);
        wrap_up();
    end

    // watchdog: whole run needs well under this
    initial begin
        #1000000;
        err_count++;
        wrap_up();
    end
endmodule : tb
